//--- bench/async_serial_receiver_assertions.sv
// Concurrent checks on the serial line and the receiver status outputs.
`timescale 1ns/1ps
module async_serial_receiver_assertions (
	// Clock, reset and line
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic line,
	// Controls
	input wire logic serial_port_enable_i,
	input wire logic continuous_receive_enable_i,
	input wire logic data_read_i,
	input wire logic receive_irq_enable_i,
	input wire logic peripheral_irq_enable_i,
	input wire logic global_irq_enable_i,
	// Status
	input wire logic receive_char_flag_o,
	input wire logic framing_error_flag_o,
	input wire logic overrun_error_flag_o,
	input wire logic receive_idle_o,
	input wire logic receive_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ==========================================================
	// Named steps
	// ==========================================================
	sequence port_held_s;
		!serial_port_enable_i [*3];
	endsequence
	sequence rx_off_s;
		!continuous_receive_enable_i [*2];
	endsequence
	sequence char_start_s;
		$fell(receive_idle_o);
	endsequence
	// ==========================================================
	// Properties
	// ==========================================================
	// interrupt needs enables
	irq_gating_a: assert property (receive_irq_o == $past(receive_char_flag_o &&
		receive_irq_enable_i && peripheral_irq_enable_i && global_irq_enable_i))
		else $error("interrupt output disagrees with flag and enables");
	flag_enable_a: assert property (receive_char_flag_o |->
		$past(continuous_receive_enable_i && serial_port_enable_i))
		else $error("receive flag high while reception disabled");
	port_reset_a: assert property (port_held_s |-> !receive_char_flag_o &&
		!framing_error_flag_o && !overrun_error_flag_o)
		else $error("status not cleared by port disable");
	overrun_clear_a: assert property (rx_off_s |-> !overrun_error_flag_o)
		else $error("overrun kept while receive disabled");
	overrun_full_a: assert property ($rose(overrun_error_flag_o) |-> receive_char_flag_o)
		else $error("overrun raised with no stored character");
	start_edge_a: assert property (char_start_s |-> !$past(line) || !$past(line, 2))
		else $error("reception began without a low line");
	char_bounded_a: assert property (char_start_s |-> ##[1:200] receive_idle_o)
		else $error("receiver did not return to idle");
	framing_error_flag_keep_a: assert property (serial_port_enable_i && $past(serial_port_enable_i) &&
		!continuous_receive_enable_i && !data_read_i && !$past(data_read_i)
		|=> $stable(framing_error_flag_o))
		else $error("framing status changed by receive disable");
endmodule : async_serial_receiver_assertions

//--- bench/async_serial_receiver_tb.sv
// Testbench joining the character sender and the receiver across one line.
`timescale 1ns/1ps
module async_serial_receiver_tb import serial_rx_pkg::*;;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic send_i = 1'b0;
	logic [DATA_BITS-1:0] send_data_i = 8'h00;
	logic send_ninth_i = 1'b0;
	logic nine_bit_i = 1'b0;
	logic stop_level_i = 1'b1;
	logic [DIVISOR_WIDTH-1:0] rate_divisor_i = 16'h0000;
	logic serial_port_enable_i = 1'b0;
	logic continuous_receive_enable_i = 1'b0;
	logic address_detect_enable_i = 1'b0;
	logic receive_irq_enable_i = 1'b0;
	logic peripheral_irq_enable_i = 1'b0;
	logic global_irq_enable_i = 1'b0;
	logic data_read_i = 1'b0;
	logic sync_mode_i = 1'b0;
	logic pin_direction_bit_i = 1'b1;
	logic analog_select_bit_i = 1'b0;
	logic busy_o;
	logic [DATA_BITS-1:0] receive_data_register_o;
	logic received_ninth_bit_o;
	logic framing_error_flag_o;
	logic overrun_error_flag_o;
	logic receive_char_flag_o;
	logic receive_idle_o;
	logic receive_irq_o;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;
	serial_line_if link_if();
	serial_char_sender u_serial_char_sender (.clk_i, .sys_rst_i, .link(link_if), .send_i,
		.send_data_i, .send_ninth_i, .nine_bit_i, .stop_level_i, .rate_divisor_i, .busy_o);
	async_serial_receiver u_async_serial_receiver (.clk_i, .sys_rst_i, .link(link_if),
		.pin_direction_bit_i, .analog_select_bit_i, .serial_port_enable_i,
		.continuous_receive_enable_i, .sync_mode_i,
		.nine_bit_receive_enable_i(nine_bit_i), .address_detect_enable_i, .rate_divisor_i,
		.receive_irq_enable_i, .peripheral_irq_enable_i, .global_irq_enable_i, .data_read_i,
		.receive_data_register_o, .received_ninth_bit_o, .framing_error_flag_o,
		.overrun_error_flag_o, .receive_char_flag_o, .receive_idle_o, .receive_irq_o);
	async_serial_receiver_assertions u_async_serial_receiver_assertions (.clk_i, .sys_rst_i,
		.line(link_if.line), .serial_port_enable_i, .continuous_receive_enable_i,
		.data_read_i, .receive_irq_enable_i, .peripheral_irq_enable_i, .global_irq_enable_i,
		.receive_char_flag_o, .framing_error_flag_o, .overrun_error_flag_o, .receive_idle_o,
		.receive_irq_o);
	// ==========================================================
	// Clock, timeout and tasks
	// ==========================================================
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	// Some twenty characters take about 3200 cycles, so the ceiling leaves wide margin.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// The wait after busy falls covers the push-to-output latency of the receiver.
	task automatic send(input logic [7:0] d, input logic n9, input logic stp);
		int w = 0;
		send_data_i = d;
		send_ninth_i = n9;
		stop_level_i = stp;
		send_i = 1'b1;
		cyc(1);
		send_i = 1'b0;
		while (busy_o !== 1'b0 && w < 400) begin
			cyc(1);
			w++;
		end
		cyc(3);
	endtask : send
	task automatic pop;
		data_read_i = 1'b1;
		cyc(1);
		data_read_i = 1'b0;
		cyc(2);
	endtask : pop
	task automatic finish_test;
		if (err_total == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		cyc(12);
		sys_rst_i = 1'b0;
		cyc(1);
		serial_port_enable_i = 1'b1;
		continuous_receive_enable_i = 1'b1;
		receive_irq_enable_i = 1'b1;
		peripheral_irq_enable_i = 1'b1;
		cyc(1);
		send(8'ha5, 1'b0, 1'b1);
		check(receive_char_flag_o, 9'h001);
		check({received_ninth_bit_o, receive_data_register_o}, 9'h0a5);
		check(framing_error_flag_o, 9'h000);
		check(receive_irq_o, 9'h000);
		global_irq_enable_i = 1'b1;
		cyc(2);
		check(receive_irq_o, 9'h001);
		pop();
		check(receive_char_flag_o, 9'h000);
		// false start
		// The pin opens while bit zero is low, so the start check finds bit one high.
		pin_direction_bit_i = 1'b0;
		send_data_i = 8'hfe;
		send_ninth_i = 1'b0;
		stop_level_i = 1'b1;
		send_i = 1'b1;
		cyc(1);
		send_i = 1'b0;
		cyc(27);
		pin_direction_bit_i = 1'b1;
		cyc(170);
		check(receive_char_flag_o, 9'h000);
		check(receive_idle_o, 9'h001);
		send(8'h3c, 1'b0, 1'b0);
		send(8'h81, 1'b0, 1'b1);
		check(framing_error_flag_o, 9'h001);
		check(receive_data_register_o, 9'h03c);
		pop();
		check(framing_error_flag_o, 9'h000);
		check(receive_data_register_o, 9'h081);
		pop();
		send(8'h00, 1'b0, 1'b0);
		continuous_receive_enable_i = 1'b0;
		cyc(3);
		check(receive_char_flag_o, 9'h000);
		check(framing_error_flag_o, 9'h001);
		continuous_receive_enable_i = 1'b1;
		cyc(3);
		check(receive_char_flag_o, 9'h001);
		serial_port_enable_i = 1'b0;
		cyc(3);
		check(framing_error_flag_o, 9'h000);
		check(receive_char_flag_o, 9'h000);
		serial_port_enable_i = 1'b1;
		cyc(2);
		send(8'h11, 1'b0, 1'b1);
		send(8'h22, 1'b0, 1'b1);
		send(8'h33, 1'b0, 1'b1);
		check(overrun_error_flag_o, 9'h001);
		check(receive_data_register_o, 9'h011);
		pop();
		check(receive_data_register_o, 9'h022);
		pop();
		send(8'h44, 1'b0, 1'b1);
		check(receive_char_flag_o, 9'h000);
		continuous_receive_enable_i = 1'b0;
		cyc(3);
		check(overrun_error_flag_o, 9'h000);
		continuous_receive_enable_i = 1'b1;
		cyc(2);
		send(8'h55, 1'b0, 1'b1);
		check(receive_data_register_o, 9'h055);
		pop();
		nine_bit_i = 1'b1;
		send(8'h96, 1'b1, 1'b1);
		check({received_ninth_bit_o, receive_data_register_o}, 9'h196);
		pop();
		address_detect_enable_i = 1'b1;
		send(8'h5a, 1'b0, 1'b1);
		check(receive_char_flag_o, 9'h000);
		send(8'h6b, 1'b1, 1'b1);
		check({received_ninth_bit_o, receive_data_register_o}, 9'h16b);
		pop();
		address_detect_enable_i = 1'b0;
		send(8'h7c, 1'b0, 1'b1);
		check({received_ninth_bit_o, receive_data_register_o}, 9'h07c);
		pop();
		continuous_receive_enable_i = 1'b0;
		send(8'h12, 1'b0, 1'b1);
		continuous_receive_enable_i = 1'b1;
		cyc(2);
		check(receive_char_flag_o, 9'h000);
		sync_mode_i = 1'b1;
		send(8'h12, 1'b0, 1'b1);
		sync_mode_i = 1'b0;
		cyc(2);
		check(receive_char_flag_o, 9'h000);
		analog_select_bit_i = 1'b1;
		send(8'h34, 1'b0, 1'b1);
		analog_select_bit_i = 1'b0;
		cyc(2);
		check(receive_char_flag_o, 9'h000);
		send(8'h56, 1'b0, 1'b1);
		check(receive_data_register_o, 9'h056);
		finish_test();
	end
endmodule : async_serial_receiver_tb

//--- rtl/async_serial_receiver.sv
// Asynchronous serial receiver with two-entry FIFO and error status.
`timescale 1ns/1ps
module async_serial_receiver
	import serial_rx_pkg::*;
#(
	parameter int DIV_W = DIVISOR_WIDTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Link
	serial_line_if.receiver link,
	// Pin configuration
	input wire logic pin_direction_bit_i,
	input wire logic analog_select_bit_i,
	// Control bits
	input wire logic serial_port_enable_i,
	input wire logic continuous_receive_enable_i,
	input wire logic sync_mode_i,
	input wire logic nine_bit_receive_enable_i,
	input wire logic address_detect_enable_i,
	input wire logic [DIV_W-1:0] rate_divisor_i,
	// Interrupt enables
	input wire logic receive_irq_enable_i,
	input wire logic peripheral_irq_enable_i,
	input wire logic global_irq_enable_i,
	// Data read
	input wire logic data_read_i,
	output logic [DATA_BITS-1:0] receive_data_register_o,
	output logic received_ninth_bit_o,
	// Status
	output logic framing_error_flag_o,
	output logic overrun_error_flag_o,
	output logic receive_char_flag_o,
	output logic receive_idle_o,
	output logic receive_irq_o
);

	// Majority of three samples: the value seen at least twice.
	function automatic logic majority3(input logic a, input logic b, input logic c);
		majority3 = (a & b) | (a & c) | (b & c);
	endfunction : majority3

	rx_state_e state;
	logic active;
	logic rx_in;
	logic line_prev;
	logic [DIV_W-1:0] div_cnt;
	logic tick;
	logic [3:0] os_cnt;
	logic [1:0] maj_sh;
	logic decide;
	logic maj;
	logic [3:0] bit_idx;
	logic [CHAR_BITS-1:0] shreg;
	logic char_done;
	logic char_framing_error_flag;
	logic [CHAR_BITS-1:0] char_word;
	logic accept;
	logic pop;
	logic [1:0] count;
	logic [CHAR_BITS-1:0] ent_data [FIFO_DEPTH];
	logic ent_framing_error_flag [FIFO_DEPTH];

	assign active = continuous_receive_enable_i && !sync_mode_i && serial_port_enable_i;
	// A misconfigured pin reads as idle mark so no character can start.
	// pin configuration dependency
	assign rx_in = (pin_direction_bit_i && !analog_select_bit_i) ? link.line : LINE_MARK;
	assign tick = (div_cnt == '0);
	assign decide = tick && (os_cnt == SAMPLE_C);
	assign maj = majority3(maj_sh[1], maj_sh[0], rx_in);
	assign char_done = decide && (state == RX_STOP);
	assign char_framing_error_flag = (maj == LINE_SPACE);
	assign char_word = nine_bit_receive_enable_i ? shreg : {1'b0, shreg[CHAR_BITS-1:1]};
	assign accept = !address_detect_enable_i || (nine_bit_receive_enable_i && shreg[CHAR_BITS-1]);
	assign pop = data_read_i && (count != COUNT_EMPTY);

	// ==========================================================
	// Oversampling clock
	// ==========================================================
	// sixteen ticks per bit
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt <= '0;
		end else if (!active || tick) begin
			div_cnt <= rate_divisor_i;
		end else begin
			div_cnt <= div_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			os_cnt <= OS_FIRST;
		end else if (!active || state == RX_IDLE) begin
			os_cnt <= OS_FIRST;
		end else if (tick) begin
			os_cnt <= os_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			maj_sh <= 2'h3;
			line_prev <= LINE_MARK;
		end else begin
			line_prev <= rx_in;
			if (tick && (os_cnt == SAMPLE_A || os_cnt == SAMPLE_B)) begin
				maj_sh <= {maj_sh[0], rx_in};
			end
		end
	end

	// ==========================================================
	// Character recovery
	// ==========================================================
	// disabled port holds reset
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= RX_IDLE;
			bit_idx <= 4'h0;
			shreg <= CHAR_RESET;
		end else if (!active) begin
			state <= RX_IDLE;
			bit_idx <= 4'h0;
		end else begin
			case (state)
				RX_IDLE: begin
					if (line_prev == LINE_MARK && rx_in == LINE_SPACE) begin
						state <= RX_START;
					end
				end
				RX_START: begin
					if (decide) begin
						state <= (maj == LINE_SPACE) ? RX_DATA : RX_IDLE;
						bit_idx <= 4'h0;
					end
				end
				RX_DATA: begin
					if (decide) begin
						shreg <= {maj, shreg[CHAR_BITS-1:1]};
						bit_idx <= bit_idx + 1'b1;
						if (bit_idx == (nine_bit_receive_enable_i ? LAST_BIT_9 : LAST_BIT_8)) begin
							state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (decide) begin
						state <= RX_IDLE;
					end
				end
				default: begin
					state <= RX_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Receive FIFO, oldest entry always in slot zero
	// ==========================================================
	// Keeping the oldest entry in slot zero lets the status and data outputs
	// come straight from storage, at the cost of a shift on every pop.
	// two entry FIFO
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count <= COUNT_EMPTY;
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				ent_data[i] <= CHAR_RESET;
				ent_framing_error_flag[i] <= 1'b0;
			end
		end else if (!serial_port_enable_i) begin
			count <= COUNT_EMPTY;
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				ent_data[i] <= CHAR_RESET;
				ent_framing_error_flag[i] <= 1'b0;
			end
		end else begin
			if (char_done && accept && !overrun_error_flag_o) begin
				case (count)
					COUNT_EMPTY: begin
						ent_data[0] <= char_word;
						ent_framing_error_flag[0] <= char_framing_error_flag;
						count <= COUNT_ONE;
					end
					COUNT_ONE: begin
						if (pop) begin
							ent_data[0] <= char_word;
							ent_framing_error_flag[0] <= char_framing_error_flag;
						end else begin
							ent_data[1] <= char_word;
							ent_framing_error_flag[1] <= char_framing_error_flag;
							count <= COUNT_FULL;
						end
					end
					default: begin
						if (pop) begin
							ent_data[0] <= ent_data[1];
							ent_framing_error_flag[0] <= ent_framing_error_flag[1];
							ent_data[1] <= char_word;
							ent_framing_error_flag[1] <= char_framing_error_flag;
						end
					end
				endcase
			end else if (pop) begin
				ent_data[0] <= ent_data[1];
				ent_framing_error_flag[0] <= ent_framing_error_flag[1];
				count <= count - 1'b1;
			end
		end
	end

	// ==========================================================
	// Status and interrupt outputs
	// ==========================================================
	// overrun on third character
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			overrun_error_flag_o <= 1'b0;
		end else if (!active) begin
			overrun_error_flag_o <= 1'b0;
		end else if (char_done && accept && count == COUNT_FULL && !pop) begin
			overrun_error_flag_o <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			receive_data_register_o <= '0;
			received_ninth_bit_o <= 1'b0;
			framing_error_flag_o <= 1'b0;
		end else begin
			receive_data_register_o <= ent_data[0][DATA_BITS-1:0];
			received_ninth_bit_o <= ent_data[0][CHAR_BITS-1];
			framing_error_flag_o <= ent_framing_error_flag[0];
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			receive_char_flag_o <= 1'b0;
			receive_idle_o <= 1'b1;
		end else begin
			receive_char_flag_o <= active && (count != COUNT_EMPTY);
			receive_idle_o <= (state == RX_IDLE);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			receive_irq_o <= 1'b0;
		end else begin
			receive_irq_o <= receive_char_flag_o && receive_irq_enable_i
				&& peripheral_irq_enable_i && global_irq_enable_i;
		end
	end

endmodule : async_serial_receiver

//--- rtl/serial_char_sender.sv
// Remote transmitter end: sends NRZ characters, LSB first, onto the line.
`timescale 1ns/1ps
module serial_char_sender
	import serial_rx_pkg::*;
#(
	parameter int DIV_W = DIVISOR_WIDTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Link
	serial_line_if.transmitter link,
	// Character request
	input wire logic send_i,
	input wire logic [DATA_BITS-1:0] send_data_i,
	input wire logic send_ninth_i,
	input wire logic nine_bit_i,
	input wire logic stop_level_i,
	input wire logic [DIV_W-1:0] rate_divisor_i,
	// Status
	output logic busy_o
);

	tx_state_e state;
	logic [DIV_W-1:0] div_cnt;
	logic tick;
	logic [3:0] os_cnt;
	logic [3:0] bit_idx;
	logic [CHAR_BITS-1:0] shreg;
	logic nine_q;
	logic stop_q;
	logic line_q;
	logic bit_end;

	assign tick = (div_cnt == '0);
	assign bit_end = tick && (os_cnt == OS_LAST);
	assign link.line = line_q;

	// ==========================================================
	// Bit-rate divider, sixteen ticks per bit
	// ==========================================================
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt <= '0;
		end else if (state == TX_IDLE || tick) begin
			div_cnt <= rate_divisor_i;
		end else begin
			div_cnt <= div_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			os_cnt <= OS_FIRST;
		end else if (state == TX_IDLE) begin
			os_cnt <= OS_FIRST;
		end else if (tick) begin
			os_cnt <= os_cnt + 1'b1;
		end
	end

	// ==========================================================
	// Framing sequence
	// ==========================================================
	// LSB first framing
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= TX_IDLE;
			shreg <= CHAR_RESET;
			bit_idx <= 4'h0;
			nine_q <= 1'b0;
			stop_q <= LINE_MARK;
			line_q <= LINE_MARK;
			busy_o <= 1'b0;
		end else begin
			case (state)
				TX_IDLE: begin
					line_q <= LINE_MARK;
					if (send_i) begin
						shreg <= {send_ninth_i, send_data_i};
						nine_q <= nine_bit_i;
						stop_q <= stop_level_i;
						state <= TX_START;
						line_q <= LINE_SPACE;
						busy_o <= 1'b1;
					end
				end
				TX_START: begin
					if (bit_end) begin
						state <= TX_DATA;
						bit_idx <= 4'h0;
						line_q <= shreg[0];
					end
				end
				TX_DATA: begin
					if (bit_end) begin
						shreg <= {1'b0, shreg[CHAR_BITS-1:1]};
						bit_idx <= bit_idx + 1'b1;
						if (bit_idx == (nine_q ? LAST_BIT_9 : LAST_BIT_8)) begin
							state <= TX_STOP;
							line_q <= stop_q;
						end else begin
							line_q <= shreg[1];
						end
					end
				end
				TX_STOP: begin
					if (bit_end) begin
						state <= TX_IDLE;
						line_q <= LINE_MARK;
						busy_o <= 1'b0;
					end
				end
				default: begin
					state <= TX_IDLE;
				end
			endcase
		end
	end

endmodule : serial_char_sender

//--- rtl/serial_line_if.sv
// Single-wire asynchronous serial line between transmitter and receiver.
`timescale 1ns/1ps
interface serial_line_if;
	logic line;
	modport transmitter (output line);
	modport receiver (input line);
endinterface : serial_line_if

//--- rtl/serial_rx_pkg.sv
// Shared constants and state types for the asynchronous serial link.
package serial_rx_pkg;

	// ==========================================================
	// Framing and timing
	// ==========================================================
	localparam int OVERSAMPLE = 16;
	localparam int DATA_BITS = 8;
	localparam int CHAR_BITS = 9;
	localparam int DIVISOR_WIDTH = 16;
	localparam int FIFO_DEPTH = 2;
	localparam logic [3:0] OS_FIRST = 4'h0;
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_B = 4'h8;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] LAST_BIT_8 = 4'h7;
	localparam logic [3:0] LAST_BIT_9 = 4'h8;

	// ==========================================================
	// Line levels and reset values
	// ==========================================================
	localparam logic LINE_MARK = 1'b1;
	localparam logic LINE_SPACE = 1'b0;
	localparam logic [8:0] CHAR_RESET = 9'h000;
	localparam logic [1:0] COUNT_EMPTY = 2'h0;
	localparam logic [1:0] COUNT_ONE = 2'h1;
	localparam logic [1:0] COUNT_FULL = 2'h2;

	// ==========================================================
	// State types
	// ==========================================================
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;

endpackage : serial_rx_pkg
